// ### inc/wcm_pkg.sv
// ==========================================================
// watchdog / clock monitor constants
package wcm_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [7:0] SVC_KEY_REG_OFS = 8'h00;
  localparam logic [4:0] SVC_KEY = 5'h0C;
  localparam logic [4:0] KEY_READBACK = 5'h00;
  localparam logic [1:0] WIN_RESET = 2'h3;
  localparam logic CM_EN_RESET = 1'b1;
  localparam logic [16:0] LOWER_LIMIT = 17'h00800;
  localparam logic [16:0] UPPER_8K = 17'h02000;
  localparam logic [16:0] UPPER_16K = 17'h04000;
  localparam logic [16:0] UPPER_32K = 17'h08000;
  localparam logic [16:0] UPPER_64K = 17'h10000;
  // extra ticks the pin is held low once sensed low
  localparam logic [4:0] FAULT_HOLD_TICKS = 5'h10;
  // good instruction cycles before a clock error clears
  localparam logic [4:0] CM_RECOVER_TICKS = 5'h10;
  // longest instruction-cycle gap accepted, microseconds
  localparam int CM_REJECT_US = 1000;
  localparam int CM_REJECT_CYC = CM_REJECT_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    WCM_HIGH_SPEED,
    WCM_DUAL_CLOCK,
    WCM_LOW_SPEED
  } wcm_speed_t;

  typedef struct packed {
    logic [1:0] win;
    logic [4:0] key;
    logic cm_en;
  } wcm_svc_t;
endpackage : wcm_pkg

// ### rtl/wcm_top.sv
`timescale 1ns/10ps
module wcm_top
  import wcm_pkg::*;
#(
  parameter int CM_REJECT_CYCLES = CM_REJECT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic instr_tick,
  input wire logic slow_tick,
  input wire wcm_speed_t speed_mode,
  input wire logic option_wd_off,
  input wire logic halt_mode,
  input wire logic idle_mode,
  input wire logic idle_exit,
  input wire logic boot_rom_entry,
  input wire logic fault_pin_in,
  output logic fault_out,
  output logic fault_oe_n
);

  // ==========================================================
  // decode
  typedef enum logic [1:0] {
    WD_RUN,
    WD_DRIVE,
    WD_HOLD,
    WD_WAIT_HIGH
  } wcm_wd_state_t;

  wcm_wd_state_t wd_state_reg;
  wcm_wd_state_t wd_state_next;
  logic [16:0] win_cnt_reg;
  logic [16:0] win_cnt_next;
  logic [1:0] win_reg;
  logic cm_en_reg;
  logic first_done_reg;
  logic lower_skip_reg;
  logic [4:0] hold_cnt_reg;
  logic [4:0] hold_cnt_next;
  logic [31:0] gap_cnt_reg;
  logic cm_err_reg;
  logic [4:0] good_cnt_reg;
  logic [7:0] reg_rdata_reg;
  logic fault_oe_n_reg;

  wire wd_present = ~option_wd_off;
  wire wcm_svc_t svc = wcm_svc_t'(reg_wdata);
  wire svc_hit = reg_wr && (reg_addr == SVC_KEY_REG_OFS);
  wire rd_hit = reg_rd && (reg_addr == SVC_KEY_REG_OFS);
  wire key_ok = (svc.key == SVC_KEY);
  wire win_ok = (svc.win == win_reg);
  wire cm_ok = (svc.cm_en == cm_en_reg);
  wire full_ok = key_ok && win_ok && cm_ok;
  wire suspended = halt_mode || idle_mode;
  wire idle_tick_raw = (speed_mode == WCM_HIGH_SPEED) ? instr_tick : slow_tick;
  wire idle_tick = idle_tick_raw && !suspended;
  wire early = (win_cnt_reg < LOWER_LIMIT) && !lower_skip_reg;

  logic [16:0] upper_limit;
  always_comb begin
    case (win_reg)
      2'h0: upper_limit = UPPER_8K;
      2'h1: upper_limit = UPPER_16K;
      2'h2: upper_limit = UPPER_32K;
      default: upper_limit = UPPER_64K;
    endcase
  end

  // ==========================================================
  // service evaluation
  wire running = wd_present && (wd_state_reg == WD_RUN);
  // only a running watchdog with pin high looks at writes
  wire svc_take = svc_hit && running && fault_pin_in;
  wire first_ok = !first_done_reg && key_ok;
  wire later_ok = first_done_reg && full_ok && !early;
  wire svc_good = svc_take && (first_ok || later_ok);
  wire svc_bad = svc_take && !(first_ok || later_ok);
  wire expire = running && idle_tick && (win_cnt_reg == upper_limit - 17'h00001);
  wire hw_svc = running && (boot_rom_entry || idle_exit);
  wire wd_err = svc_bad || expire;
  wire restart = svc_good || hw_svc;

  // ==========================================================
  // watchdog state machine
  always_comb begin
    wd_state_next = wd_state_reg;
    hold_cnt_next = hold_cnt_reg;
    win_cnt_next = win_cnt_reg;
    case (wd_state_reg)
      WD_RUN: begin
        if (wd_err) begin
          wd_state_next = WD_DRIVE;
          win_cnt_next = 17'h00000;
        end else if (restart) begin
          win_cnt_next = 17'h00000;
        end else if (idle_tick) begin
          win_cnt_next = win_cnt_reg + 17'h00001;
        end
      end
      WD_DRIVE: begin
        hold_cnt_next = 5'h00;
        if (!fault_pin_in) begin
          wd_state_next = WD_HOLD;
        end
      end
      WD_HOLD: begin
        if (instr_tick) begin
          hold_cnt_next = hold_cnt_reg + 5'h01;
          if (hold_cnt_reg == FAULT_HOLD_TICKS - 5'h01) begin
            wd_state_next = WD_WAIT_HIGH;
          end
        end
      end
      WD_WAIT_HIGH: begin
        win_cnt_next = 17'h00000;
        if (fault_pin_in) begin
          wd_state_next = WD_RUN;
        end
      end
      default: begin
        wd_state_next = WD_RUN;
      end
    endcase
  end

  // everything idle in reset, values on release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wd_state_reg <= WD_RUN;
      win_cnt_reg <= 17'h00000;
      hold_cnt_reg <= 5'h00;
    end else if (clk_en) begin
      wd_state_reg <= wd_state_next;
      win_cnt_reg <= win_cnt_next;
      hold_cnt_reg <= hold_cnt_next;
    end
  end

  // ==========================================================
  // latched service settings
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      win_reg <= WIN_RESET;
      cm_en_reg <= CM_EN_RESET;
      first_done_reg <= 1'b0;
    end else if (clk_en && svc_good && !first_done_reg) begin
      win_reg <= svc.win;
      cm_en_reg <= svc.cm_en;
      first_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lower_skip_reg <= 1'b1;
    end else if (clk_en) begin
      if (boot_rom_entry && running) begin
        lower_skip_reg <= 1'b1;
      end else if (svc_good || idle_exit || wd_err) begin
        lower_skip_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // clock monitor
  wire gap_over = (gap_cnt_reg >= CM_REJECT_CYCLES);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_cnt_reg <= 32'h00000000;
    end else if (clk_en) begin
      if (instr_tick) begin
        gap_cnt_reg <= 32'h00000000;
      end else if (!gap_over) begin
        gap_cnt_reg <= gap_cnt_reg + 32'h00000001;
      end
    end
  end

  // set on a long gap, cleared after a run of good cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cm_err_reg <= 1'b0;
      good_cnt_reg <= 5'h00;
    end else if (clk_en) begin
      if (!cm_en_reg || !wd_present) begin
        cm_err_reg <= 1'b0;
        good_cnt_reg <= 5'h00;
      end else if (gap_over) begin
        cm_err_reg <= 1'b1;
        good_cnt_reg <= 5'h00;
      end else if (cm_err_reg && instr_tick) begin
        good_cnt_reg <= good_cnt_reg + 5'h01;
        if (good_cnt_reg == CM_RECOVER_TICKS - 5'h01) begin
          cm_err_reg <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // pin and register read
  wire wd_drive = (wd_state_next == WD_DRIVE) || (wd_state_next == WD_HOLD);
  wire drive_low = wd_present && (wd_drive || cm_err_reg);
  wire [7:0] rd_value = {win_reg, KEY_READBACK, cm_en_reg};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_oe_n_reg <= 1'b1;
      reg_rdata_reg <= 8'h00;
    end else if (clk_en) begin
      fault_oe_n_reg <= ~drive_low;
      reg_rdata_reg <= rd_hit ? rd_value : 8'h00;
    end
  end

  // pin only ever driven low; high comes from the pull-up
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_out <= 1'b0;
    end else if (clk_en) begin
      fault_out <= 1'b0;
    end
  end

  assign fault_oe_n = fault_oe_n_reg;
  assign reg_rdata = reg_rdata_reg;

endmodule : wcm_top

// ### tb/wcm_top_props.sv
`timescale 1ns/10ps
// ==========================================
// port checker
module wcm_top_props
  import wcm_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic instr_tick,
  input wire logic option_wd_off,
  input wire logic fault_pin_in,
  input wire logic fault_out,
  input wire logic fault_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ticks seen while the pin is driven
  logic [4:0] tick_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) tick_cnt <= 5'h00;
    else if (fault_oe_n) tick_cnt <= 5'h00;
    else if (clk_en && instr_tick && tick_cnt != 5'h1F) tick_cnt <= tick_cnt + 5'h01;
  end
  chk_out_low: assert property (fault_out == 1'b0)
    else $error("fault data not low");
  chk_reset_quiet: assert property (!$past(reset_n) |-> fault_oe_n && reg_rdata == 8'h00)
    else $error("activity right after reset");
  chk_key_zero: assert property (reg_rd && clk_en && reg_addr == SVC_KEY_REG_OFS
    |=> reg_rdata[5:1] == KEY_READBACK) else $error("key field readable");
  chk_rd_idle: assert property (!(reg_rd && clk_en) |=> reg_rdata == 8'h00)
    else $error("read data without read");
  chk_unmapped_zero: assert property (reg_rd && reg_addr != SVC_KEY_REG_OFS
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_wd_absent: assert property (option_wd_off |-> fault_oe_n)
    else $error("pin driven with watchdog off");
  chk_bad_key: assert property (reg_wr && clk_en && reg_addr == SVC_KEY_REG_OFS
    && reg_wdata[5:1] != SVC_KEY && fault_oe_n && $past(fault_oe_n) && $past(fault_pin_in)
    && !option_wd_off |=> !fault_oe_n) else $error("bad key not flagged");
  chk_hold_len: assert property ($rose(fault_oe_n) |-> tick_cnt inside {[5'h10:5'h12]})
    else $error("fault hold length wrong");
  cov_fault: cover property ($fell(fault_oe_n));
  cov_release: cover property ($rose(fault_oe_n));
  cov_write: cover property (reg_wr && clk_en);
endmodule : wcm_top_props

bind wcm_top wcm_top_props i_wcm_top_props (
  .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_tick(instr_tick),
  .option_wd_off(option_wd_off), .fault_pin_in(fault_pin_in), .fault_out(fault_out),
  .fault_oe_n(fault_oe_n)
);

// ### tb/wcm_pin_model.sv
`timescale 1ns/10ps
// ==========================================
// open-drain fault line with pull-up
module wcm_pin_model (
  input wire logic fault_out,
  input wire logic fault_oe_n,
  output logic fault_pin_in
);
  // released line floats up to the pull-up level
  assign fault_pin_in = fault_oe_n ? 1'b1 : fault_out;
endmodule : wcm_pin_model

// ### tb/tb.sv
`timescale 1ns/10ps
module tb
  import wcm_pkg::*;
;
  logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, instr_tick = 1'b0;
  logic tick_on = 1'b0, boot = 1'b0, wd_off = 1'b0, idle_ex = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic fault_out, fault_oe_n, fault_pin_in;
  int n_fail = 0, check_count = 0, cyc = 0, n;
  // ==========================================
  // design and pin
  wcm_top #(.CM_REJECT_CYCLES(200)) i_wcm_top (
    .clk(clk), .reset_n(reset_n), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_tick(instr_tick),
    .slow_tick(instr_tick), .speed_mode(WCM_HIGH_SPEED), .option_wd_off(wd_off),
    .halt_mode(1'b0), .idle_mode(1'b0), .idle_exit(idle_ex), .boot_rom_entry(boot),
    .fault_pin_in(fault_pin_in), .fault_out(fault_out), .fault_oe_n(fault_oe_n)
  );
  wcm_pin_model i_wcm_pin_model (
    .fault_out(fault_out), .fault_oe_n(fault_oe_n), .fault_pin_in(fault_pin_in)
  );
  initial forever #5 clk = ~clk;
  always @(posedge clk) instr_tick <= tick_on && !instr_tick;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      summarize();
    end
  end
  // ==========================================
  // tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : idle
  task automatic wait_oe(input logic v, input int lim);
    n = 0;
    while (fault_oe_n !== v && n < lim) begin
      idle(1);
      n++;
    end
    chk(8'(fault_oe_n), 8'(v));
  endtask : wait_oe
  task automatic fault(input int lim);
    wait_oe(1'b0, lim);
    wait_oe(1'b1, 40);
  endtask : fault
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  // ==========================================
  // tests
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    tick_on <= 1'b1;
    rd(8'h01, 8'h00);
    rd(SVC_KEY_REG_OFS, 8'hC1);
    wr(8'h18);
    idle(20);
    chk(8'(fault_oe_n), 8'h01);
    rd(SVC_KEY_REG_OFS, 8'h00);
    $display("test first service done");
    idle(4200);
    wr(8'h18);
    @(posedge clk);
    boot <= 1'b1;
    @(posedge clk);
    boot <= 1'b0;
    wr(8'h18);
    idle(20);
    chk(8'(fault_oe_n), 8'h01);
    wr(8'h18);
    wait_oe(1'b0, 4);
    wr(8'hFF);
    wait_oe(1'b1, 40);
    chk(8'(n > 28), 8'h01);
    idle(20);
    chk(8'(fault_oe_n), 8'h01);
    $display("test early service done");
    idle(4200);
    wr(8'h58);
    fault(4);
    idle(4200);
    wr(8'h10);
    fault(4);
    idle(15800);
    chk(8'(fault_oe_n), 8'h01);
    fault(800);
    idle(4200);
    @(posedge clk);
    idle_ex <= 1'b1;
    @(posedge clk);
    idle_ex <= 1'b0;
    wr(8'h18);
    fault(4);
    $display("test window errors done");
    @(posedge clk);
    reset_n <= 1'b0;
    tick_on <= 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    wait_oe(1'b0, 300);
    @(posedge clk);
    tick_on <= 1'b1;
    wait_oe(1'b1, 60);
    @(posedge clk);
    reset_n <= 1'b0;
    wd_off <= 1'b1;
    tick_on <= 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    idle(300);
    chk(8'(fault_oe_n), 8'h01);
    $display("test clock monitor done");
    summarize();
  end
endmodule : tb
